//--- hdl/fmac_consts.vh
`ifndef FMAC_CONSTS_VH
`define FMAC_CONSTS_VH
// operation codes from the instruction decoder
`define FMAC_OP_NONE      3'h0
`define FMAC_OP_MASKS     3'h1
`define FMAC_OP_LOADOPS   3'h2
`define FMAC_OP_CLEAR     3'h3
`define FMAC_OP_MAC       3'h4
`define FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE      3'h5
`define FMAC_OP_XFER_RND  3'h6
// widths
`define FMAC_ACC_W        36
`define FMAC_PROD_W       32
// overflow bit positions
`define FMAC_SAT_BIT      31
`define FMAC_EXT_BIT      35
// saturation values for acc bits 31:16
`define FMAC_SAT_POS      16'h7fff
`define FMAC_SAT_NEG      16'h8000
// example mask for a 64-entry ring
`define FMAC_MASK_64      16'h3f3f
// repeat timing in core cycles
`define FMAC_REPEATED_MULTIPLY_ACCUMULATE_FIRST   18
`define FMAC_REPEATED_MULTIPLY_ACCUMULATE_NEXT    12
`define FMAC_CNT_W        5
`endif

//--- hdl/fmac_ptr_step.v
`timescale 1ns/1ps
// post-increment of an index pointer with modulo wrap inside the mask
module fmac_ptr_step (
  input  wire [15:0] ptr,      // current pointer
  input  wire [3:0]  offset,   // signed post-increment offset
  input  wire [7:0]  mask,     // modulo mask, zero disables wrap
  output wire [15:0] ptr_next  // updated pointer
);
  wire [15:0] ofs_ext;
  wire [15:0] sum;
  wire [15:0] wmask;

  assign ofs_ext  = {{12{offset[3]}}, offset};
  assign sum      = ptr + ofs_ext;
  assign wmask    = {8'h00, mask};
  // bits under the mask follow the sum, the rest stays as the ring base
  assign ptr_next = (mask == 8'h00) ? sum :
                    ((ptr & ~wmask) | (sum & wmask));
endmodule // fmac_ptr_step

//--- hdl/fmac_unit.v
`timescale 1ns/1ps
`include "fmac_consts.vh"
// How it works
// - load-masks loads both masks from double accumulator
// - load-operands fetches X and Y words into operands
// - repeat step: accumulate, post-increment, decrement count, reload
// - independent post-increment offsets, zero allowed
// - transfer-rounded moves rounded result into accumulator E
// - overflow into bit 31 sets saturation flag
// - overflow into bit 35 sets extension flag
// - extension overflow sign kept in hidden latch
// - saturation mode is a writable condition bit
// - saturation forces bits 31:16 to limit value
// - 36-bit accumulator, two 16-bit operands
// - 32-bit product added to lower accumulator bits
// - repeat takes 18 then 12 cycles, interruptible
// - nonzero mask wraps pointer, zero disables wrap
module fmac_unit (
  input  wire        sys_clk,      // core clock
  input  wire        rst_n,        // async reset, active low
  input  wire        op_valid,     // one-cycle operation strobe
  input  wire [2:0]  op_code,      // operation select
  input  wire [3:0]  ofs_x,        // x pointer offset
  input  wire [3:0]  ofs_y,        // y pointer offset
  input  wire [31:0] acc_de_in,    // double accumulator e:d
  input  wire        load_ptrs,    // load both index pointers
  input  wire [15:0] x_ptr_in,     // new x index pointer
  input  wire [15:0] y_ptr_in,     // new y index pointer
  input  wire        load_count,   // load the loop count
  input  wire [15:0] count_in,     // new loop count
  input  wire        sm_wr,        // write the saturation mode bit
  input  wire        sm_in,        // saturation mode value
  input  wire        irq_pending,  // interrupt wants the core
  input  wire [15:0] mem_x_data,   // data at x pointer
  input  wire [15:0] mem_y_data,   // data at y pointer
  output reg  [15:0] x_ptr_r,      // x index pointer
  output reg  [15:0] y_ptr_r,      // y index pointer
  output reg  [15:0] count_r,      // loop-count accumulator e
  output reg  [35:0] acc_r,        // wide accumulator
  output reg         sat_flag_r,   // saturation overflow flag
  output reg         ext_flag_r,   // extension overflow flag
  output reg         sm_r,         // saturation mode bit
  output reg         busy_r,       // operation in progress
  output reg         done_r        // operation finished pulse
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_STEP = 2'h2;
  localparam ST_LOAD = 2'h3;

  reg [1:0]             state_r;
  reg                   repeat_r;
  reg [`FMAC_CNT_W-1:0] wait_r;
  reg [3:0]             ofx_r;
  reg [3:0]             ofy_r;
  reg [7:0]             x_wrap_mask_r;
  reg [7:0]             y_wrap_mask_r;
  reg [15:0]            op_a_r;
  reg [15:0]            op_b_r;
  reg                   sign_latch_r;

  wire [15:0] x_nxt;
  wire [15:0] y_nxt;
  wire [31:0] prod;
  wire [35:0] sum;
  wire        sat_ovf;
  wire        ext_ovf;
  wire        carry_sign;
  wire [15:0] rnd;

  fmac_ptr_step u_step_x (
    .ptr      (x_ptr_r),
    .offset   (ofx_r),
    .mask     (x_wrap_mask_r),
    .ptr_next (x_nxt)
  );
  fmac_ptr_step u_step_y (
    .ptr      (y_ptr_r),
    .offset   (ofy_r),
    .mask     (y_wrap_mask_r),
    .ptr_next (y_nxt)
  );

  assign prod = $signed(op_a_r) * $signed(op_b_r);
  assign sum  = acc_r + {{4{prod[31]}}, prod};
  // bit 31 overflow: sign of 32-bit part disagrees with bit 35 extension
  assign sat_ovf = sum[31] != sum[35];
  // bit 35 overflow: both signs equal and result sign differs
  assign carry_sign = acc_r[35];
  assign ext_ovf = (acc_r[35] == prod[31]) &&
                   (sum[35] != acc_r[35]);
  // convergent rounding of bits 31:0 to 16 bits, ties to even
  assign rnd = (acc_r[15] && (acc_r[14:0] != 15'h0000 || acc_r[16])) ?
               acc_r[31:16] + 16'h0001 : acc_r[31:16];

  // one accumulation with flags and optional saturation
  task do_accumulate;
    reg [35:0] res;
    reg        neg;
    begin
      res = sum;
      neg = ext_ovf ? carry_sign : sum[35];
      if (ext_ovf) begin
        ext_flag_r   <= 1'b1;
        sign_latch_r <= carry_sign;
      end
      if (sat_ovf || ext_ovf)
        sat_flag_r <= 1'b1;
      // a stored sign keeps saturating after an earlier wrap
      if (ext_flag_r && !ext_ovf)
        neg = sign_latch_r;
      if (sm_r && (sat_ovf || ext_ovf || ext_flag_r || sat_flag_r))
        res[31:16] = neg ? `FMAC_SAT_NEG : `FMAC_SAT_POS;
      acc_r <= res;
    end
  endtask

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      repeat_r     <= 1'b0;
      wait_r       <= {`FMAC_CNT_W{1'b0}};
      ofx_r        <= 4'h0;
      ofy_r        <= 4'h0;
      x_wrap_mask_r      <= 8'h00;
      y_wrap_mask_r      <= 8'h00;
      op_a_r       <= 16'h0000;
      op_b_r       <= 16'h0000;
      sign_latch_r <= 1'b0;
      x_ptr_r      <= 16'h0000;
      y_ptr_r      <= 16'h0000;
      count_r      <= 16'h0000;
      acc_r        <= 36'h000000000;
      sat_flag_r   <= 1'b0;
      ext_flag_r   <= 1'b0;
      sm_r         <= 1'b0;
      busy_r       <= 1'b0;
      done_r       <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (sm_wr)
        sm_r <= sm_in;
      case (state_r)
        ST_IDLE: begin
          if (load_ptrs) begin
            x_ptr_r <= x_ptr_in;
            y_ptr_r <= y_ptr_in;
          end
          if (load_count)
            count_r <= count_in;
          if (op_valid) begin
            if (op_code == `FMAC_OP_MASKS) begin
              x_wrap_mask_r <= acc_de_in[15:8];
              y_wrap_mask_r <= acc_de_in[7:0];
              done_r  <= 1'b1;
            end else if (op_code == `FMAC_OP_LOADOPS) begin
              op_a_r <= mem_x_data;
              op_b_r <= mem_y_data;
              done_r <= 1'b1;
            end else if (op_code == `FMAC_OP_CLEAR) begin
              acc_r      <= 36'h000000000;
              sat_flag_r <= 1'b0;
              ext_flag_r <= 1'b0;
              done_r     <= 1'b1;
            end else if (op_code == `FMAC_OP_XFER_RND) begin
              count_r <= rnd;
              done_r  <= 1'b1;
            end else if (op_code == `FMAC_OP_MAC ||
                         op_code == `FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE) begin
              ofx_r    <= ofs_x;
              ofy_r    <= ofs_y;
              repeat_r <= (op_code == `FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE);
              busy_r   <= 1'b1;
              // first pass carries the longer setup time; the step
              // lands on cycle 18 (repeat) or 11 (single), reload after
              wait_r   <= (op_code == `FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE) ?
                          `FMAC_CNT_W'd16 : `FMAC_CNT_W'd9;
              state_r  <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (wait_r == {`FMAC_CNT_W{1'b0}})
            state_r <= ST_STEP;
          else
            wait_r <= wait_r - `FMAC_CNT_W'd1;
        end
        ST_STEP: begin
          do_accumulate;
          x_ptr_r <= x_nxt;
          y_ptr_r <= y_nxt;
          if (repeat_r)
            count_r <= count_r - 16'h0001;
          state_r <= ST_LOAD;
        end
        ST_LOAD: begin
          // memory follows x_ptr_r/y_ptr_r, so the words at the new
          // addresses are only there one cycle after the pointer move
          op_a_r <= mem_x_data;
          op_b_r <= mem_y_data;
          // count already stepped: all ones means it started at zero;
          // an interrupt leaves pointers and count valid to resume
          if (!repeat_r || count_r == 16'h0000 ||
              count_r == 16'hffff || irq_pending) begin
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            wait_r  <= `FMAC_CNT_W'd9;
            state_r <= ST_WAIT;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // fmac_unit

//--- verif/fmac_checker.sv
`timescale 1ns/1ps
module fmac_checker (
  input wire        sys_clk,    // core clock
  input wire        rst_n,      // async reset
  input wire        op_valid,   // op strobe
  input wire [2:0]  op_code,    // op select
  input wire        sm_wr,      // mode write
  input wire        sm_in,      // mode value
  input wire [15:0] count_r,    // loop count
  input wire [35:0] acc_r,      // accumulator
  input wire        sat_flag_r, // sat flag
  input wire        ext_flag_r, // ext flag
  input wire        sm_r,       // mode bit
  input wire        busy_r,     // busy
  input wire        done_r      // done pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire take = op_valid && !busy_r;
  chk_clear_zero: assert property (take && op_code == 3'h3
    |=> acc_r == 36'h0 && !sat_flag_r && !ext_flag_r) else $error("clear");
  chk_short_done: assert property (take && op_code == 3'h1
    |=> done_r) else $error("mask load no done");
  chk_mac_busy: assert property (take && op_code == 3'h4
    |=> busy_r[*8]) else $error("mac busy dropped");
  chk_mac_done: assert property (take && op_code == 3'h4
    |-> ##13 done_r) else $error("mac latency");
  chk_repeated_multiply_accumulate_first: assert property (take && op_code == 3'h5
    |-> ##19 $changed(count_r)) else $error("first step late");
  chk_count_step: assert property ($past(busy_r) && $changed(count_r)
    |-> count_r == $past(count_r) - 16'h1) else $error("count step");
  chk_sat_limit: assert property ($fell(busy_r) && sm_r
    && (sat_flag_r || ext_flag_r)
    |-> acc_r[31:16] inside {16'h7fff, 16'h8000}) else $error("sat value");
  chk_sat_cause: assert property ($rose(sat_flag_r)
    |-> $past(busy_r)) else $error("sat flag cause");
  chk_ext_cause: assert property ($rose(ext_flag_r)
    |-> $past(busy_r)) else $error("ext flag cause");
  chk_mode_write: assert property (sm_wr
    |=> sm_r == $past(sm_in)) else $error("mode write");
endmodule // fmac_checker
bind fmac_unit fmac_checker i_fmac_checker (.sys_clk, .rst_n, .op_valid,
  .op_code, .sm_wr, .sm_in, .count_r, .acc_r, .sat_flag_r, .ext_flag_r,
  .sm_r, .busy_r, .done_r);

//--- verif/fmac_mem_model.sv
`timescale 1ns/1ps
// one word value per table; odd addresses read inverted so a pointer
// that drifts off a word boundary shows up in the sums
module fmac_mem_model (
  input  wire [15:0] x_ptr,  // x address
  input  wire [15:0] y_ptr,  // y address
  input  wire [15:0] x_word, // x table word
  input  wire [15:0] y_word, // y table word
  output wire [15:0] x_data, // x read data
  output wire [15:0] y_data  // y read data
);
  assign x_data = x_ptr[0] ? ~x_word : x_word;
  assign y_data = y_ptr[0] ? ~y_word : y_word;
endmodule // fmac_mem_model

//--- verif/fmac_unit_tb.sv
`timescale 1ns/1ps
`include "fmac_consts.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  err_count++; $display("CHECK FAILED %0t got %h exp %h", $time, a, e); \
  end end
module fmac_unit_tb;
  logic        sys_clk = 0, rst_n = 0, op_valid = 0, lds = 0, sm_in = 0;
  logic        irq = 0;
  logic [31:0] de = {16'h0000, `FMAC_MASK_64};
  logic [2:0]  op_code = 0;
  logic [3:0]  ofs_x = 0, ofs_y = 0;
  logic [15:0] px = 0, py = 0, cnt = 0, wx = 0, wy = 0;
  wire  [15:0] mx, my, x_ptr_r, y_ptr_r, count_r;
  wire  [35:0] acc_r;
  wire         sat_flag_r, ext_flag_r, sm_r, busy_r, done_r;
  int          err_count = 0, n_compared = 0, cyc = 0, k;
  always #2 sys_clk = ~sys_clk;
  fmac_unit i_fmac_unit (.sys_clk, .rst_n, .op_valid, .op_code, .ofs_x,
    .ofs_y, .acc_de_in(de), .load_ptrs(lds), .x_ptr_in(px),
    .y_ptr_in(py), .load_count(lds), .count_in(cnt), .sm_wr(lds), .sm_in,
    .irq_pending(irq), .mem_x_data(mx), .mem_y_data(my), .x_ptr_r,
    .y_ptr_r, .count_r, .acc_r, .sat_flag_r, .ext_flag_r, .sm_r, .busy_r,
    .done_r);
  fmac_mem_model i_fmac_mem_model (.x_ptr(x_ptr_r), .y_ptr(y_ptr_r),
    .x_word(wx), .y_word(wy), .x_data(mx), .y_data(my));
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      stop_test;
    end
  end
  // waits on busy with a bound; short ops finish on the next edge
  task op(input [2:0] c, input [3:0] ox, input [3:0] oy);
    @(posedge sys_clk);
    op_code <= c;
    ofs_x <= ox;
    ofs_y <= oy;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
    for (k = 0; k < 600 && busy_r !== 1'b0; k++) @(posedge sys_clk) #1;
  endtask
  task ld(input [15:0] x, y, c, input s, input [15:0] a, b);
    @(posedge sys_clk);
    px <= x;
    py <= y;
    cnt <= c;
    sm_in <= s;
    wx <= a;
    wy <= b;
    lds <= 1'b1;
    @(posedge sys_clk);
    lds <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    `CHK({acc_r, count_r, sat_flag_r, ext_flag_r, sm_r, busy_r, done_r}, 57'h0)
    ld(16'h0100, 16'h0200, 16'h0003, 1'b1, 16'h4000, 16'h2000);
    `CHK(sm_r, 1'b1)
    op(`FMAC_OP_MASKS, 4'h0, 4'h0);
    op(`FMAC_OP_LOADOPS, 4'h0, 4'h0);
    op(`FMAC_OP_CLEAR, 4'h0, 4'h0);
    `CHK(acc_r, 36'h0)
    op(`FMAC_OP_MAC, 4'h0, 4'h2);
    `CHK({x_ptr_r, y_ptr_r}, 32'h0100_0202)
    `CHK(acc_r, 36'h008000000)
    $display("test single step done");
    // pointers sit at the ring's top so the next step wraps
    ld(16'h013f, 16'h023e, 16'h0003, 1'b0, 16'h4000, 16'h2000);
    op(`FMAC_OP_MAC, 4'h2, 4'h2);
    `CHK({x_ptr_r, y_ptr_r}, 32'h0101_0200)
    op(`FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE, 4'h2, 4'h2);
    `CHK({count_r, x_ptr_r, y_ptr_r}, 48'h0000_0107_0206)
    // odd x addresses read the inverted word, so the sum turns negative
    `CHK(acc_r, 36'hff7ffa000)
    op(`FMAC_OP_XFER_RND, 4'h0, 4'h0);
    `CHK(count_r, 16'hf800)
    $display("test repeat done");
    ld(16'h0100, 16'h0200, 16'h0000, 1'b0, 16'h0003, 16'h3000);
    op(`FMAC_OP_LOADOPS, 4'h0, 4'h0);
    op(`FMAC_OP_CLEAR, 4'h0, 4'h0);
    op(`FMAC_OP_MAC, 4'h0, 4'h0);
    op(`FMAC_OP_XFER_RND, 4'h0, 4'h0);
    `CHK(count_r, 16'h0001)
    $display("test rounding done");
    ld(16'h0100, 16'h0200, 16'h0003, 1'b1, 16'h7fff, 16'h7fff);
    op(`FMAC_OP_LOADOPS, 4'h0, 4'h0);
    op(`FMAC_OP_CLEAR, 4'h0, 4'h0);
    op(`FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE, 4'h0, 4'h0);
    `CHK({sat_flag_r, ext_flag_r}, 2'b10)
    `CHK(acc_r[31:16], 16'h7fff)
    op(`FMAC_OP_CLEAR, 4'h0, 4'h0);
    `CHK({acc_r, sat_flag_r, ext_flag_r}, 38'h0)
    $display("test saturation done");
    // 32 steps of +0.5 carry the sum into bit 35 with wrapping allowed
    ld(16'h0100, 16'h0200, 16'h0020, 1'b0, 16'h8000, 16'h8000);
    op(`FMAC_OP_LOADOPS, 4'h0, 4'h0);
    op(`FMAC_OP_CLEAR, 4'h0, 4'h0);
    op(`FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE, 4'h0, 4'h0);
    `CHK(acc_r, 36'h800000000)
    `CHK({sat_flag_r, ext_flag_r}, 2'b11)
    // the latched sign, not bit 35, picks the positive limit
    ld(16'h0100, 16'h0200, 16'h0000, 1'b1, 16'h8000, 16'h8000);
    op(`FMAC_OP_MAC, 4'h0, 4'h0);
    `CHK(acc_r, 36'h87fff0000)
    $display("test extension overflow done");
    @(posedge sys_clk);
    de <= 32'h0000_0000;
    op(`FMAC_OP_MASKS, 4'h0, 4'h0);
    irq <= 1'b1;
    ld(16'h013e, 16'h0200, 16'h0003, 1'b0, 16'h4000, 16'h2000);
    op(`FMAC_OP_REPEATED_MULTIPLY_ACCUMULATE, 4'h2, 4'hf);
    `CHK(count_r, 16'h0002)
    `CHK({x_ptr_r, y_ptr_r}, 32'h0140_01ff)
    irq <= 1'b0;
    $display("test no wrap and interrupt done");
    stop_test;
  end
endmodule // fmac_unit_tb
